// [table_latch_xor_test_exec.sv]
// Execution unit: table latch write, test-skip-if-zero, exclusive-OR
// Operation
// - Latch write copies register into one byte
// - Select bit picks high or low byte
// - Latch held for later program memory write
// - Zero register discards prefetch, two cycles
// - Literal XOR into working register, zero flag
// - Register XOR, destination bit picks target
`timescale 1ns/100ps
`default_nettype none
`include "exec_defs.svh"
module table_latch_xor_test_exec #(
    parameter int DATA_W = 8,
    parameter int INSTR_W = 16,
    parameter int LATCH_W = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr_word,
    input wire logic [DATA_W-1:0] file_rdata,
    output logic [LATCH_W-1:0] table_latch,
    output logic [DATA_W-1:0] working_register,
    output logic zero_flag,
    output logic file_we,
    output logic [DATA_W-1:0] file_wdata,
    output logic [DATA_W-1:0] file_waddr,
    output logic flush_prefetch,
    output logic busy,
    output logic [1:0] qphase
);
    import exec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Refuse sizes the fixed opcode fields cannot serve: the low byte of a
    // 16-bit word is a file address or a literal, and the latch is two bytes
    localparam int LATCH_BYTES = LATCH_W / DATA_W;

    localparam logic [DATA_W-1:0] ZERO_BYTE = '0;

    if (DATA_W != 8) begin : g_bad_data_w
        $error("DATA_W must be 8");
    end

    if (INSTR_W != 16) begin : g_bad_instr_w
        $error("INSTR_W must be 16");
    end

    if (LATCH_W != 2 * DATA_W) begin : g_bad_latch_w
        $error("LATCH_W must hold exactly two data bytes");
    end

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        // Architectural state
        logic [LATCH_W-1:0] latch;
        logic [DATA_W-1:0] work;
        logic zero;

        // One-cycle strobes, plus write data and address held until the next write, toward the file and the fetch stage
        logic we;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] waddr;
        logic flush;

        // Skip and quarter phase tracking
        logic nop_cycle;
        logic [1:0] q;
    } state_t;

    // Reset pattern: everything clear, phase at the first quarter
    localparam state_t ST_RESET = '{
        latch: `LATCH_RESET,
        work: `WORK_RESET,
        zero: `ZERO_RESET,
        we: `STROBE_RESET,
        wdata: `FILE_WR_RESET,
        waddr: `FILE_WR_RESET,
        flush: `STROBE_RESET,
        nop_cycle: `STROBE_RESET,
        q: `QPHASE_RESET
    };

    state_t st_r;
    state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Decoded instruction
    op_kind_t kind;
    logic sel_bit;
    logic use_literal;

    // Phase and issue qualifiers
    logic exec_slot;
    logic take;
    logic to_file;

    // Datapath
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    logic result_zero;
    logic rdata_zero;
    wire logic [LATCH_BYTES-1:0] byte_sel;
    wire logic [LATCH_W-1:0] latch_upd;

    // Opcode fields are decoded apart so that this file only sequences them
    exec_decode u_dec (
        .opcode(instr_word),
        .kind(kind),
        .sel_bit(sel_bit),
        .use_literal(use_literal)
    );

    ////////////////////////////////////////////////////////////////////////
    // One instruction cycle is four core clocks; work lands on the last one
    assign exec_slot = (st_r.q == `QPHASE_LAST);

    // The cycle after a taken skip runs as a no-operation: the word shown then
    // is the discarded prefetch and must not execute
    assign take = exec_slot && instr_valid && !st_r.nop_cycle;

    // Only the register form can send its result back to the file
    assign to_file = !use_literal && sel_bit;

    ////////////////////////////////////////////////////////////////////////
    // The same exclusive-OR serves both forms; only the operand differs
    assign operand = use_literal ? instr_word[DATA_W-1:0] : file_rdata;

    assign result = st_r.work ^ operand;

    assign result_zero = (result == ZERO_BYTE);

    // The test instruction looks at the register itself, not at a result
    assign rdata_zero = (file_rdata == ZERO_BYTE);

    ////////////////////////////////////////////////////////////////////////
    // Each latch byte loads the file register or keeps its value; byte one
    // is the high half and answers a set select bit
    for (genvar b = 0; b < LATCH_BYTES; b++) begin : g_byte
        assign byte_sel[b] = (int'(sel_bit) == b);

        assign latch_upd[b*DATA_W +: DATA_W] = byte_sel[b]
            ? file_rdata
            : st_r.latch[b*DATA_W +: DATA_W];
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobes default low so each one lasts exactly one core clock
    always_comb begin
        st_nxt = st_r;
        st_nxt.we = 1'b0;
        st_nxt.flush = 1'b0;

        // Phase wraps on the write slot, which also ends a skipped cycle
        if (exec_slot) begin
            st_nxt.q = `QPHASE_RESET;
            st_nxt.nop_cycle = 1'b0;
        end else begin
            st_nxt.q = 2'(st_r.q + 2'h1);
        end

        if (take) begin
            case (kind)
                OP_TLW: begin
                    // Latch keeps its value until the next table latch write or a reset
                    st_nxt.latch = latch_upd;
                end

                OP_TST: begin
                    // Skip costs one extra instruction cycle; flags stay
                    if (rdata_zero) begin
                        st_nxt.flush = 1'b1;
                        st_nxt.nop_cycle = 1'b1;
                    end
                end

                OP_XOR: begin
                    st_nxt.zero = result_zero;
                    // The literal form always writes back to the working register
                    if (to_file) begin
                        st_nxt.we = 1'b1;
                        st_nxt.wdata = result;
                        st_nxt.waddr = instr_word[DATA_W-1:0];
                    end else begin
                        st_nxt.work = result;
                    end
                end

                default: begin
                    // Unknown words leave all state alone
                    st_nxt.zero = st_r.zero;
                end
            endcase
        end
    end

    // A synchronous clear; the whole reset pattern is built once above
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Every output is a register field, so nothing combinational leaves
    assign table_latch = st_r.latch;
    assign working_register = st_r.work;
    assign zero_flag = st_r.zero;

    // Write port toward the file registers
    assign file_we = st_r.we;
    assign file_wdata = st_r.wdata;
    assign file_waddr = st_r.waddr;

    // Fetch-side controls and phase
    assign flush_prefetch = st_r.flush;
    assign busy = st_r.nop_cycle;
    assign qphase = st_r.q;
endmodule : table_latch_xor_test_exec
`default_nettype wire

// [exec_defs.svh]
// Constants for the table latch, test-skip and exclusive-OR execution block
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH
`define OPC_TLW_HI6 6'h29
`define OPC_TST_HI8 8'h33
`define OPC_XLIT_HI8 8'hb4
`define OPC_XREG_HI7 7'h06
`define LATCH_RESET 16'h0000
`define WORK_RESET 8'h00
`define ZERO_RESET 1'b0
`define STROBE_RESET 1'b0
`define FILE_WR_RESET 8'h00
`define QPHASE_RESET 2'h0
`define QPHASE_LAST 2'h3
`endif

// [exec_pkg.sv]
// Types for the table latch, test-skip and exclusive-OR execution block
package exec_pkg;
    typedef enum logic [3:0] {
        OP_NONE = 4'b0001,
        OP_TLW = 4'b0010,
        OP_TST = 4'b0100,
        OP_XOR = 4'b1000
    } op_kind_t;
endpackage : exec_pkg

// [exec_decode.sv]
// Opcode decoder for the execution block
`timescale 1ns/100ps
`default_nettype none
`include "exec_defs.svh"
module exec_decode (
    input wire logic [15:0] opcode,
    output var exec_pkg::op_kind_t kind,
    output logic sel_bit,
    output logic use_literal
);
    import exec_pkg::*;
    always_comb begin
        kind = OP_NONE;
        sel_bit = 1'b0;
        use_literal = 1'b0;
        if (opcode[15:10] == `OPC_TLW_HI6) begin
            kind = OP_TLW;
            sel_bit = opcode[9];
        end else if (opcode[15:8] == `OPC_TST_HI8) begin
            kind = OP_TST;
        end else if (opcode[15:8] == `OPC_XLIT_HI8) begin
            kind = OP_XOR;
            use_literal = 1'b1;
        end else if (opcode[15:9] == `OPC_XREG_HI7) begin
            kind = OP_XOR;
            sel_bit = opcode[8];
        end
    end
endmodule : exec_decode
`default_nettype wire

// [exec_props.sv]
// Checker for the table latch, test-skip and exclusive-OR block
`timescale 1ns/100ps
`default_nettype none
module exec_props (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [7:0] file_rdata,
    input wire logic [15:0] table_latch,
    input wire logic [7:0] working_register,
    input wire logic zero_flag,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] file_waddr,
    input wire logic flush_prefetch,
    input wire logic busy,
    input wire logic [1:0] qphase
);
    wire logic tk = qphase == 2'h3 && instr_valid && !busy;
    wire logic [7:0] op = instr_word[15:8];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence nop_cycle;
        busy [*4] ##1 !busy;
    endsequence
    a_latch_high: assert property (
        tk && op[7:1] == 7'h53 |=> table_latch[15:8] == $past(file_rdata)) else $error("latch hi");
    a_latch_low: assert property (
        tk && op[7:1] == 7'h52 |=> table_latch[7:0] == $past(file_rdata)
        && $stable(table_latch[15:8])) else $error("latch lo");
    a_latch_hold: assert property (
        !(tk && op[7:2] == 6'h29) |=> $stable(table_latch)) else $error("latch moved");
    a_skip_nop: assert property (
        tk && op == 8'h33 && file_rdata == 8'h00 |=> flush_prefetch ##0 nop_cycle)
        else $error("skip");
    a_xor_lit: assert property (
        tk && op == 8'hb4 |=> working_register == $past(working_register ^ instr_word[7:0]))
        else $error("xor lit");
    a_xor_dest: assert property (
        tk && op == 8'h0d |=> file_we && file_wdata == $past(working_register ^ file_rdata)
        && file_waddr == $past(instr_word[7:0])
        && $stable(working_register)) else $error("xor file");
    a_zero_xor: assert property (
        tk && (op == 8'hb4 || op == 8'h0c) |=> zero_flag == (working_register == 8'h00))
        else $error("zero");
    a_zero_hold: assert property (
        tk && (op[7:2] == 6'h29 || op == 8'h33) |=> $stable(zero_flag))
        else $error("zero moved");
endmodule : exec_props
bind table_latch_xor_test_exec exec_props u_exec_props (.*);
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the execution block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic core_clk = 0, rst_n = 0, instr_valid = 0, busy, file_we, flush_prefetch, zero_flag, z = 0;
    logic [15:0] instr_word = 0, table_latch, lat = 0, rnd_w;
    logic [7:0] file_rdata = 0, working_register, file_wdata, file_waddr, wr = 0, fw, rnd_d;
    logic [7:0] ops [7] = '{8'ha4, 8'ha7, 8'h33, 8'hb4, 8'h0c, 8'h0d, 8'hff};
    logic [1:0] qphase;
    int fails = 0, compares = 0;
    table_latch_xor_test_exec u_table_latch_xor_test_exec (.*);
    initial forever #2.5 core_clk = ~core_clk;
    task chk(string n, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    function automatic logic [15:0] lw(logic [15:0] l, logic hi, logic [7:0] d);
        return hi ? {d, l[7:0]} : {l[15:8], d};
    endfunction : lw
    task run(logic [15:0] w, logic [7:0] rd);
        logic s, we;
        for (int i = 0; i < 20 && (qphase !== 2'h3 || busy !== 1'b0); i++) @(posedge core_clk) #1;
        instr_valid = 1;
        instr_word = w;
        file_rdata = rd;
        s = 0;
        we = 0;
        fw = wr ^ rd;
        if (w[15:10] == 6'h29) lat = lw(lat, w[9], rd);
        else if (w[15:8] == 8'h33) s = rd == 8'h00;
        else if (w[15:8] == 8'hb4) begin
            wr = wr ^ w[7:0];
            z = wr == 8'h00;
        end else if (w[15:9] == 7'h06) begin
            z = fw == 8'h00;
            if (w[8]) we = 1;
            else wr = fw;
        end
        @(posedge core_clk) #1;
        instr_valid = 0;
        chk("latch", lat, table_latch);
        chk("work", wr, working_register);
        chk("zero", z, zero_flag);
        chk("flush", s, flush_prefetch);
        chk("we", we, file_we);
        if (we) chk("wdata", fw, file_wdata);
        if (we) chk("waddr", w[7:0], file_waddr);
        chk("busy", s, busy);
        chk("qphase", 2'h0, qphase);
    endtask : run
    task complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial begin
        void'($urandom(57202));
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1;
        // Walk through the worked example, then zero results and both latch bytes
        run(16'h3300, 8'h00);
        run(16'hb4b5, 8'h00);
        run(16'hb4af, 8'h00);
        run(16'h0d00, 8'h1a);
        run(16'h0c00, 8'h1a);
        run(16'ha6ff, 8'hb7);
        run(16'ha401, 8'h5c);
        $display("corner test done");
        repeat (60) begin
            rnd_w = {ops[$urandom % 7], 8'($urandom)};
            rnd_d = ($urandom % 4) ? 8'($urandom) : 8'h00;
            run(rnd_w, rnd_d);
        end
        $display("random test done");
        complete_run;
    end
    initial begin
        #20000;
        fails++;
        complete_run;
    end
endmodule : tb_top
`default_nettype wire
